// File: core/rps_cfg.svh
// register offsets, field positions, reset values for the pin select block
// assumes: included by bare name from package and modules
`ifndef RPS_CFG_SVH
`define RPS_CFG_SVH
`define RPS_ADDR_W          3
`define RPS_OFF_IN_A_SENT   3'h0
`define RPS_OFF_IN_B_C      3'h1
`define RPS_OFF_OUT_0_1     3'h2
`define RPS_OFF_OUT_2_3     3'h3
`define RPS_OFF_IN_PWM      3'h4
`define RPS_HI_MSB          15
`define RPS_HI_LSB          8
`define RPS_LO_MSB          7
`define RPS_LO_LSB          0
`define RPS_OUT_W           6
`define RPS_VOUT_LO_LSB     0
`define RPS_VOUT_HI_LSB     8
`define RPS_OUT_MASK        16'h3F3F
`define RPS_RESET_VAL       16'h0000
`define RPS_NUM_PINS        256
`define RPS_NUM_FUNCS       64
`endif

// File: core/rps_pkg.sv
// types shared by the pin select block
// assumes: rps_cfg.svh on the include path
`include "rps_cfg.svh"
package rps_pkg;
  typedef logic [7:0]                   rps_pin_sel_t;
  typedef logic [`RPS_OUT_W-1:0]        rps_func_sel_t;
  typedef logic [`RPS_ADDR_W-1:0]       rps_addr_t;
  typedef logic [15:0]                  rps_data_t;
  typedef logic [`RPS_NUM_PINS-1:0]     rps_pins_t;
  typedef logic [`RPS_NUM_FUNCS-1:0]    rps_funcs_t;
endpackage

// File: core/rps_sel_if.sv
// selector bundle passed from register file to the routing module
// assumes: rps_pkg compiled first
`timescale 1ns/100ps
interface rps_sel_if;
  import rps_pkg::*;
  rps_pin_sel_t  in_a;
  rps_pin_sel_t  in_b;
  rps_pin_sel_t  in_c;
  rps_pin_sel_t  sent;
  rps_pin_sel_t  pwm10;
  rps_pin_sel_t  pwm11;
  rps_func_sel_t vout [4];
  modport regs  (output in_a, in_b, in_c, sent, pwm10, pwm11, vout);
  modport route (input in_a, in_b, in_c, sent, pwm10, pwm11, vout);
endinterface

// File: core/rps_route.sv
// routing of remappable pins and output functions, registered outputs
// assumes: pins already synchronised; selector 0 means not connected
`timescale 1ns/100ps
module rps_route
(
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // selectors
  rps_sel_if.route                 sel,
  // sources
  input  wire rps_pkg::rps_pins_t  pins,
  input  wire rps_pkg::rps_pins_t  slave_pins,
  input  wire rps_pkg::rps_funcs_t funcs,
  // routed signals
  output logic                     logic_cell_input_a,
  output logic                     logic_cell_input_b,
  output logic                     logic_cell_input_c,
  output logic                     sent_rx_in,
  output logic                     slave_pwm_input_10,
  output logic                     slave_pwm_input_11,
  output logic [3:0]               virtual_out
);
  import rps_pkg::*;

  // zero selects nothing, so the input idles low
  function automatic logic pick_pin(input rps_pins_t p, input rps_pin_sel_t s);
    pick_pin = (s == 8'h00) ? 1'b0 : p[s];
  endfunction

  function automatic logic pick_func(input rps_funcs_t f, input rps_func_sel_t s);
    pick_func = (s == 6'h00) ? 1'b0 : f[s];
  endfunction

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      logic_cell_input_a <= 1'b0;
      logic_cell_input_b <= 1'b0;
      logic_cell_input_c <= 1'b0;
      sent_rx_in         <= 1'b0;
      slave_pwm_input_10 <= 1'b0;
      slave_pwm_input_11 <= 1'b0;
    end else begin
      logic_cell_input_a <= pick_pin(pins, sel.in_a);         // [R1] [R10]
      sent_rx_in         <= pick_pin(pins, sel.sent);         // [R2] [R10]
      logic_cell_input_c <= pick_pin(pins, sel.in_c);         // [R3] [R10]
      logic_cell_input_b <= pick_pin(pins, sel.in_b);         // [R4] [R10]
      slave_pwm_input_11 <= pick_pin(slave_pins, sel.pwm11);  // [R8] [R10]
      slave_pwm_input_10 <= pick_pin(slave_pins, sel.pwm10);  // [R9] [R10]
    end
  end

  // virtual ports stay inside the device, no pad drive
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      virtual_out <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        virtual_out[i] <= pick_func(funcs, sel.vout[i]);      // [R5] [R6] [R10]
      end
    end
  end
endmodule

// File: core/rps_top.sv
// peripheral pin select: selector registers and routing
// assumes: plain register port, read data one cycle after read strobe
`timescale 1ns/100ps
`include "rps_cfg.svh"

// Function
// R1 - The upper byte of the first input-select register picks the pin that drives logic cell input A.
// R2 - The lower byte of the first input-select register picks the pin that drives the SENT receiver input.
// R3 - The upper byte of the second input-select register picks the pin that drives logic cell input C.
// R4 - The lower byte of the second input-select register picks the pin that drives logic cell input B.
// R5 - Each of four virtual output ports has a 6-bit function selector at bits 13-8 or 5-0.
// R6 - The virtual output ports have no pad and their signals are used only inside the device.
// R7 - Bits 15-14 and 7-6 of the output-select registers ignore writes and read as zero.
// R8 - The upper byte of the slave PWM select register picks the slave pin that drives PWM input 11.
// R9 - The lower byte of the slave PWM select register picks the slave pin that drives PWM input 10.
// R10 - Every selector clears to zero on reset and zero leaves its target unconnected.
module rps_top
(
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // register port
  input  wire rps_pkg::rps_addr_t  reg_addr,
  input  wire rps_pkg::rps_data_t  reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output rps_pkg::rps_data_t       reg_rdata,
  // pad inputs, asynchronous
  input  wire rps_pkg::rps_pins_t  remappable_pin,
  input  wire rps_pkg::rps_pins_t  slave_remappable_pin,
  // peripheral output functions, same clock
  input  wire rps_pkg::rps_funcs_t periph_func,
  // routed peripheral inputs
  output logic                     logic_cell_input_a,
  output logic                     logic_cell_input_b,
  output logic                     logic_cell_input_c,
  output logic                     sent_rx_two_in,
  output logic                     slave_pwm_input_10,
  output logic                     slave_pwm_input_11,
  // internal virtual output ports
  output logic [3:0]               virtual_out
);
  import rps_pkg::*;

  rps_data_t in_a_sent_r;
  rps_data_t in_b_c_r;
  rps_data_t out_0_1_r;
  rps_data_t out_2_3_r;
  rps_data_t in_pwm_r;
  rps_data_t rdata_nxt;

  rps_pins_t pin_s1_r;
  rps_pins_t pin_s2_r;
  rps_pins_t pin_s3_r;
  rps_pins_t pin_r;
  rps_pins_t spin_s1_r;
  rps_pins_t spin_s2_r;
  rps_pins_t spin_s3_r;
  rps_pins_t spin_r;

  rps_sel_if sel ();

  // selector registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_a_sent_r <= `RPS_RESET_VAL;                         // [R10]
      in_b_c_r    <= `RPS_RESET_VAL;
      out_0_1_r   <= `RPS_RESET_VAL;
      out_2_3_r   <= `RPS_RESET_VAL;
      in_pwm_r    <= `RPS_RESET_VAL;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `RPS_OFF_IN_A_SENT: in_a_sent_r <= reg_wdata;        // [R1] [R2]
        `RPS_OFF_IN_B_C:    in_b_c_r    <= reg_wdata;        // [R3] [R4]
        `RPS_OFF_OUT_0_1:   out_0_1_r   <= reg_wdata & `RPS_OUT_MASK; // [R7]
        `RPS_OFF_OUT_2_3:   out_2_3_r   <= reg_wdata & `RPS_OUT_MASK; // [R7]
        `RPS_OFF_IN_PWM:    in_pwm_r    <= reg_wdata;        // [R8] [R9]
        default: ;
      endcase
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rdata_nxt = 16'h0000;
    unique case (reg_addr)
      `RPS_OFF_IN_A_SENT: rdata_nxt = in_a_sent_r;
      `RPS_OFF_IN_B_C:    rdata_nxt = in_b_c_r;
      `RPS_OFF_OUT_0_1:   rdata_nxt = out_0_1_r & `RPS_OUT_MASK; // [R7]
      `RPS_OFF_OUT_2_3:   rdata_nxt = out_2_3_r & `RPS_OUT_MASK; // [R7]
      `RPS_OFF_IN_PWM:    rdata_nxt = in_pwm_r;
      default:            rdata_nxt = 16'h0000;
    endcase
  end

  // data held only in the cycle after the read strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : 16'h0000;
    end
  end

  // pad synchronisers, change taken when stages two and three agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r  <= '0;
      pin_s2_r  <= '0;
      pin_s3_r  <= '0;
      pin_r     <= '0;
      spin_s1_r <= '0;
      spin_s2_r <= '0;
      spin_s3_r <= '0;
      spin_r    <= '0;
    end else begin
      pin_s1_r  <= remappable_pin;
      pin_s2_r  <= pin_s1_r;
      pin_s3_r  <= pin_s2_r;
      pin_r     <= (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r | pin_s3_r));
      spin_s1_r <= slave_remappable_pin;
      spin_s2_r <= spin_s1_r;
      spin_s3_r <= spin_s2_r;
      spin_r    <= (spin_s2_r & spin_s3_r) | (spin_r & (spin_s2_r | spin_s3_r));
    end
  end

  // selector fields onto the bundle
  assign sel.in_a    = in_a_sent_r[`RPS_HI_MSB:`RPS_HI_LSB];  // [R1]
  assign sel.sent    = in_a_sent_r[`RPS_LO_MSB:`RPS_LO_LSB];  // [R2]
  assign sel.in_c    = in_b_c_r[`RPS_HI_MSB:`RPS_HI_LSB];     // [R3]
  assign sel.in_b    = in_b_c_r[`RPS_LO_MSB:`RPS_LO_LSB];     // [R4]
  assign sel.pwm11   = in_pwm_r[`RPS_HI_MSB:`RPS_HI_LSB];     // [R8]
  assign sel.pwm10   = in_pwm_r[`RPS_LO_MSB:`RPS_LO_LSB];     // [R9]
  assign sel.vout[0] = out_0_1_r[`RPS_VOUT_LO_LSB +: `RPS_OUT_W]; // [R5]
  assign sel.vout[1] = out_0_1_r[`RPS_VOUT_HI_LSB +: `RPS_OUT_W]; // [R5]
  assign sel.vout[2] = out_2_3_r[`RPS_VOUT_LO_LSB +: `RPS_OUT_W]; // [R5]
  assign sel.vout[3] = out_2_3_r[`RPS_VOUT_HI_LSB +: `RPS_OUT_W]; // [R5]

  rps_route u_route (
    .clock              (clock),
    .rst_n              (rst_n),
    .sel                (sel.route),
    .pins               (pin_r),
    .slave_pins         (spin_r),
    .funcs              (periph_func),
    .logic_cell_input_a (logic_cell_input_a),
    .logic_cell_input_b (logic_cell_input_b),
    .logic_cell_input_c (logic_cell_input_c),
    .sent_rx_in         (sent_rx_two_in),
    .slave_pwm_input_10 (slave_pwm_input_10),
    .slave_pwm_input_11 (slave_pwm_input_11),
    .virtual_out        (virtual_out)
  );
endmodule

// File: verification/rps_checker.sv
// port assertions for the pin select block
// assumes: bound to rps_top, selector registers at indices 0 to 4
`timescale 1ns/100ps
`include "rps_cfg.svh"
module rps_checker
(
  // clock and reset
  input wire logic                clock,
  input wire logic                rst_n,
  // register port
  input wire rps_pkg::rps_addr_t  reg_addr,
  input wire rps_pkg::rps_data_t  reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire rps_pkg::rps_data_t  reg_rdata,
  // sources
  input wire rps_pkg::rps_pins_t  remappable_pin,
  input wire rps_pkg::rps_pins_t  slave_remappable_pin,
  input wire rps_pkg::rps_funcs_t periph_func,
  // routed
  input wire logic       logic_cell_input_a,
  input wire logic       logic_cell_input_b,
  input wire logic       logic_cell_input_c,
  input wire logic       sent_rx_two_in,
  input wire logic       slave_pwm_input_10,
  input wire logic       slave_pwm_input_11,
  input wire logic [3:0] virtual_out
);
  import rps_pkg::*;
  rps_data_t     sh [5];
  rps_data_t     rdexp_r;
  rps_func_sel_t fs [4];
  // shadow of the selector registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sh <= '{default: 16'h0000};
      rdexp_r <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr < 3'h5) sh[reg_addr] <= reg_wdata & (reg_addr inside {3'h2, 3'h3} ? `RPS_OUT_MASK : 16'hFFFF);
      rdexp_r <= (reg_rd && reg_addr < 3'h5) ? sh[reg_addr] : 16'h0000;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_settled(logic [7:0] s, rps_pins_t p);
    ($stable(s) && $stable(p[s]) && s != 8'h00) [*6];
  endsequence
  property p_rt(logic [7:0] s, rps_pins_t p, logic o);
    s_settled(s, p) |-> o == p[s];
  endproperty
  property p_vo(int g);
    $past(fs[g]) != 6'h00 && $past(fs[g], 2) == $past(fs[g]) |-> virtual_out[g] == $past(periph_func[fs[g]]);
  endproperty
  chk_route_a: assert property (p_rt(sh[0][15:8], remappable_pin, logic_cell_input_a)) else $error("a wrong");
  chk_route_sent: assert property (p_rt(sh[0][7:0], remappable_pin, sent_rx_two_in)) else $error("sent wrong");
  chk_route_c: assert property (p_rt(sh[1][15:8], remappable_pin, logic_cell_input_c)) else $error("c wrong");
  chk_route_b: assert property (p_rt(sh[1][7:0], remappable_pin, logic_cell_input_b)) else $error("b wrong");
  chk_pwm_eleven: assert property (p_rt(sh[4][15:8], slave_remappable_pin, slave_pwm_input_11)) else $error("p11");
  chk_pwm_ten: assert property (p_rt(sh[4][7:0], slave_remappable_pin, slave_pwm_input_10)) else $error("p10");
  for (genvar g = 0; g < 4; g++) begin : g_vout
    assign fs[g] = sh[2 + g / 2][8 * (g % 2) +: 6];
    chk_vout_func: assert property (p_vo(g)) else $error("virtual output wrong");
  end
  chk_read_back: assert property ($past(reg_rd) |-> reg_rdata == rdexp_r) else $error("read data wrong");
  chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data not idle");
  chk_unsel_zero: assert property ($past(sh[0][15:8], 2) == 8'h00 && $past(sh[0][15:8]) == 8'h00
    |-> !logic_cell_input_a) else $error("unselected input driven");
  chk_reset_quiet: assert property (disable iff (1'b0) !rst_n
    |-> reg_rdata == 16'h0000 && virtual_out == 4'h0) else $error("outputs active in reset");
endmodule
bind rps_top rps_checker u_chk (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .remappable_pin(remappable_pin),
  .slave_remappable_pin(slave_remappable_pin), .periph_func(periph_func), .logic_cell_input_a(logic_cell_input_a),
  .logic_cell_input_b(logic_cell_input_b), .logic_cell_input_c(logic_cell_input_c), .sent_rx_two_in(sent_rx_two_in),
  .slave_pwm_input_10(slave_pwm_input_10), .slave_pwm_input_11(slave_pwm_input_11), .virtual_out(virtual_out));

// File: verification/remappable_pin_select_tb.sv
// self-checking bench for the pin select block
// assumes: design and checker compiled first
`timescale 1ns/100ps
module remappable_pin_select_tb;
  import rps_pkg::*;
  logic       clock = 1'b0;
  logic       rst_n;
  rps_addr_t  reg_addr = 3'h0;
  rps_data_t  reg_wdata = 16'h0000;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  rps_data_t  reg_rdata;
  rps_pins_t  pin = '0;
  rps_pins_t  spin = '0;
  rps_funcs_t func = '0;
  rps_pins_t  p;
  rps_pins_t  s;
  rps_funcs_t f;
  wire  [5:0] rt;
  wire  [3:0] vo;
  int         err_count = 0;
  int         samples_checked = 0;
  rps_top dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .remappable_pin(pin), .slave_remappable_pin(spin), .periph_func(func),
    .logic_cell_input_a(rt[0]), .logic_cell_input_b(rt[1]), .logic_cell_input_c(rt[2]), .sent_rx_two_in(rt[3]),
    .slave_pwm_input_10(rt[4]), .slave_pwm_input_11(rt[5]), .virtual_out(vo));
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input rps_addr_t a, input rps_data_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input rps_addr_t a, input rps_data_t e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    @(posedge clock);
  endtask
  // routed outputs as {pwm11, pwm10, sent, c, b, a, vout3..vout0}
  task automatic look(input logic [9:0] e);
    repeat (8) @(posedge clock);
    #1 chk({6'h00, rt, vo}, {6'h00, e});
    @(posedge clock);
  endtask
  initial begin
    forever #2 clock = ~clock;
  end
  initial begin
    #100000;
    err_count++;
    complete_run;
  end
  initial begin
    // x to 0 after all processes wait, so the reset edge is seen
    rst_n <= 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 8; i++) rd(i[2:0], 16'h0000);
    $display("test reset values done");
    for (int i = 0; i < 5; i++) wr(i[2:0], 16'hFFFF);
    for (int i = 0; i < 8; i++) rd(i[2:0], i > 4 ? 16'h0000 : (i inside {2, 3} ? 16'h3F3F : 16'hFFFF));
    $display("test register access done");
    wr(3'h0, 16'h0509);
    wr(3'h1, 16'hC8FF);
    wr(3'h2, 16'h0201);
    wr(3'h3, 16'h3F20);
    wr(3'h4, 16'h0701);
    p = '1;
    p[9] = 1'b0;
    p[200] = 1'b0;
    s = '1;
    s[1] = 1'b0;
    f = '1;
    f[2] = 1'b0;
    f[32] = 1'b0;
    pin <= p;
    spin <= s;
    func <= f;
    look(10'h239);
    pin <= ~p;
    spin <= ~s;
    func <= ~f;
    look(10'h1C6);
    // one-cycle pulse on the pin behind input a must never reach it
    pin[5] <= 1'b1;
    @(posedge clock);
    pin[5] <= 1'b0;
    repeat (8) begin
      @(posedge clock);
      #1 chk({15'h0000, rt[0]}, 16'h0000);
    end
    $display("test routing done");
    pin <= '1;
    spin <= '1;
    func <= '1;
    wr(3'h0, 16'h0000);
    wr(3'h2, 16'h0000);
    look(10'h36C);
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(3'h1, 16'h0000);
    $display("test zero selectors done");
    complete_run;
  end
endmodule
